// file: core/option_bank_pkg.sv
// Shared constants and types of the write-once option register bank
package option_bank_pkg;

  localparam int          ADDR_W       = 8;
  localparam logic [5:0]  OPT1_INDEX   = 6'h09;
  localparam logic [5:0]  OPT2_INDEX   = 6'h1E;
  localparam logic [5:0]  OPT3_INDEX   = 6'h1F;
  localparam logic [5:0]  STATUS_INDEX = 6'h20;
  localparam logic [7:0]  OPT1_ADDR    = {OPT1_INDEX, 2'b00};
  localparam logic [7:0]  OPT2_ADDR    = {OPT2_INDEX, 2'b00};
  localparam logic [7:0]  OPT3_ADDR    = {OPT3_INDEX, 2'b00};
  localparam logic [7:0]  STATUS_ADDR  = {STATUS_INDEX, 2'b00};

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [7:0]  OPT_RESET    = 8'h00;
  localparam logic        VMODE_RESET  = 1'b0;
  localparam logic [7:0]  OPT2_MASK    = 8'h7F;
  localparam logic [7:0]  OPT3_MASK    = 8'h7F;

  // Option register 1 fields
  localparam int WDOG_DIS_BIT  = 0;
  localparam int STOP_EN_BIT   = 1;
  localparam int SHORT_REC_BIT = 2;
  localparam int VMODE_BIT     = 3;
  localparam int DET_PWROFF_BIT = 4;
  localparam int DET_RSTINH_BIT = 5;
  localparam int DET_STOP_BIT  = 6;
  localparam int WDOG_PER_BIT  = 7;
  // Option register 2 fields
  localparam int SS_PU_DIS_BIT = 0;
  localparam int OSC_STOP_BIT  = 1;
  localparam int TB_PRE_BIT    = 2;
  localparam int EXT_CLK_BIT   = 3;
  localparam int SLOW_XTAL_BIT = 4;
  localparam int XTAL_EN_BIT   = 5;
  localparam int BAUD_SRC_BIT  = 6;
  // Option register 3 fields
  localparam int SPI_LOC_BIT   = 0;
  localparam int SER_LOC_BIT   = 1;
  localparam int PORT_SLEW_BIT = 2;
  localparam int CLK_SLEW_BIT  = 3;
  localparam int SPI_SLEW_BIT  = 4;
  localparam int TX_SLEW_BIT   = 5;
  localparam int RANGE_BIT     = 6;

  // Oscillator clock cycle counts
  localparam logic [17:0] WDOG_SHORT_CYCLES = 18'd8176;
  localparam logic [17:0] WDOG_LONG_CYCLES  = 18'd262128;
  localparam logic [12:0] REC_SHORT_CYCLES  = 13'd32;
  localparam logic [12:0] REC_LONG_CYCLES   = 13'd4096;
  localparam logic [12:0] STAB_XTAL_CYCLES  = 13'd4096;
  localparam logic [12:0] STAB_EXT_CYCLES   = 13'd16;

  typedef struct packed {
    logic [7:0]        opt1;
    logic [7:0]        opt2;
    logic [7:0]        opt3;
    logic [2:0]        written;
    logic              aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic              w_held;
    logic [7:0]        wdata;
    logic              wlane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } bank_state_t;

  typedef struct packed {
    logic        watchdog_disable;
    logic [17:0] watchdog_timeout_cycles;
    logic        detector_powered;
    logic        detector_active_in_stop;
    logic        detector_voltage_mode;
    logic        stop_enable;
    logic        serial_baud_source;
    logic        osc_input_pin_is_clock;
    logic        osc_output_pin_is_crystal;
    logic [12:0] monitor_stab_cycles;
    logic        monitor_crystal_range;
    logic        slow_crystal_select;
    logic [1:0]  crystal_range_code;
    logic        amp_fast_enable;
    logic        amp_mid_enable;
    logic        amp_slow_enable;
    logic        timebase_prescale_select;
    logic        slave_select_pullup_enable;
    logic        serial_tx_slew_ctrl;
    logic        spi_slew_ctrl;
    logic        clock_out_slew_ctrl;
    logic        port_slew_ctrl;
    logic        serial_pin_location;
    logic        spi_pin_location;
  } option_out_t;

endpackage

// file: core/write_once_option_registers.sv
// Write-once option register bank with AXI4-Lite access
//
// Operation
// - First write after reset sticks; reads always
// - Reset clears all bits except voltage mode
// - Only power-on reset clears voltage mode
// - Period bit picks 8176 or 262128 cycles
// - Detector runs in stop if enabled, powered
// - Reset-inhibit bit blocks detector reset requests
// - Power-off bit powers detector down
// - Voltage-mode bit picks 5-V or 3-V
// - Short-recovery bit picks 32 or 4096 cycles
// - Detector-reset stop exit always long recovery
// - Stop disabled means stop opcode is illegal
// - Watchdog disable bit stops the watchdog
// - Baud source bus clock or oscillator clock
// - Crystal enable sets 4096/16 stabilization, range
// - Slow crystal sets generator, monitor threshold
// - Timebase bit inserts divide-by-128 prescaler
// - Oscillator-in-stop keeps clocks, else held low
// - Pullup-disable clear enables slave-select pullup
// - Slow and range bits enable crystal amplifiers
// - Slow crystal forces range zero, blocks writes
// - Four slew bits select slew-controlled drive
// - Pin-location bits choose serial, SPI pins
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module write_once_option_registers (
  input  wire logic                                i_sys_clk,
  input  wire logic                                i_rst,
  input  wire logic                                i_por,
  input  wire logic [option_bank_pkg::ADDR_W-1:0]  i_awaddr,
  input  wire logic [2:0]                          i_awprot,
  input  wire logic                                i_awvalid,
  output logic                                     o_awready,
  input  wire logic [31:0]                         i_wdata,
  input  wire logic [3:0]                          i_wstrb,
  input  wire logic                                i_wvalid,
  output logic                                     o_wready,
  output logic [1:0]                               o_bresp,
  output logic                                     o_bvalid,
  input  wire logic                                i_bready,
  input  wire logic [option_bank_pkg::ADDR_W-1:0]  i_araddr,
  input  wire logic [2:0]                          i_arprot,
  input  wire logic                                i_arvalid,
  output logic                                     o_arready,
  output logic [31:0]                              o_rdata,
  output logic [1:0]                               o_rresp,
  output logic                                     o_rvalid,
  input  wire logic                                i_rready,
  input  wire logic                                i_detector_reset_req,
  input  wire logic                                i_stop_exit_by_detector,
  input  wire logic                                i_stop_opcode,
  input  wire logic                                i_in_stop_mode,
  output option_bank_pkg::option_out_t             o_options,
  output logic                                     o_detector_reset_to_sys,
  output logic                                     o_detector_on_in_stop,
  output logic [12:0]                              o_stop_recovery_cycles,
  output logic                                     o_stop_execute,
  output logic                                     o_stop_illegal,
  output logic                                     o_gen_clocks_run
);

  ////////////////////////////////////////////////////////////////////////
  // State

  option_bank_pkg::bank_state_t st;
  option_bank_pkg::bank_state_t next_st;
  logic                         vmode;
  logic                         next_vmode;
  logic                         prot_unused;
  logic [7:0]                   wr_byte;
  logic [7:0]                   rd_byte;
  logic                         rd_hit;

  assign prot_unused = ^{i_awprot, i_arprot, i_wdata[31:8], i_wstrb[3:1]};

  ////////////////////////////////////////////////////////////////////////
  // Bus handshakes

  assign o_awready = !st.aw_held && !st.bvalid;
  assign o_wready  = !st.w_held && !st.bvalid;
  assign o_arready = !st.rvalid;
  assign o_bvalid  = st.bvalid;
  assign o_bresp   = st.bresp;
  assign o_rvalid  = st.rvalid;
  assign o_rdata   = st.rdata;
  assign o_rresp   = st.rresp;

  ////////////////////////////////////////////////////////////////////////
  // Read decode

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (i_araddr)
      option_bank_pkg::OPT1_ADDR: begin
        rd_byte = st.opt1;
        rd_byte[option_bank_pkg::VMODE_BIT] = vmode;
      end
      option_bank_pkg::OPT2_ADDR: begin
        rd_byte = st.opt2;
      end
      option_bank_pkg::OPT3_ADDR: begin
        rd_byte = st.opt3;
      end
      option_bank_pkg::STATUS_ADDR: begin
        rd_byte = {5'h00, st.written};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st    = st;
    next_vmode = vmode;
    wr_byte    = st.wdata;

    if (i_awvalid && o_awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr  = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata  = i_wdata[7:0];
      next_st.wlane0 = i_wstrb[0];
    end

    if (st.bvalid && i_bready) begin
      next_st.bvalid = 1'b0;
    end

    // Both halves present: perform the write and answer
    if (st.aw_held && st.w_held) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = option_bank_pkg::RESP_OKAY;
      case (st.awaddr)
        option_bank_pkg::OPT1_ADDR: begin
          if (st.wlane0 && !st.written[0]) begin
            next_st.opt1       = st.wdata;
            next_st.written[0] = 1'b1;
            next_vmode = st.wdata[option_bank_pkg::VMODE_BIT];
          end
        end
        option_bank_pkg::OPT2_ADDR: begin
          if (st.wlane0 && !st.written[1]) begin
            next_st.opt2       = st.wdata & option_bank_pkg::OPT2_MASK;
            next_st.written[1] = 1'b1;
            if (st.wdata[option_bank_pkg::SLOW_XTAL_BIT]) begin
              next_st.opt3[option_bank_pkg::RANGE_BIT] = 1'b0;
            end
          end
        end
        option_bank_pkg::OPT3_ADDR: begin
          if (st.wlane0 && !st.written[2]) begin
            wr_byte = st.wdata & option_bank_pkg::OPT3_MASK;
            if (st.opt2[option_bank_pkg::SLOW_XTAL_BIT]) begin
              wr_byte[option_bank_pkg::RANGE_BIT] = 1'b0;
            end
            next_st.opt3       = wr_byte;
            next_st.written[2] = 1'b1;
          end
        end
        option_bank_pkg::STATUS_ADDR: begin
          next_st.bresp = option_bank_pkg::RESP_OKAY;
        end
        default: begin
          next_st.bresp = option_bank_pkg::RESP_SLVERR;
        end
      endcase
    end

    if (st.rvalid && i_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = {24'h000000, rd_byte};
      next_st.rresp  = rd_hit ? option_bank_pkg::RESP_OKAY
                              : option_bank_pkg::RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st         <= '0;
      st.opt1    <= option_bank_pkg::OPT_RESET;
      st.opt2    <= option_bank_pkg::OPT_RESET;
      st.opt3    <= option_bank_pkg::OPT_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Voltage mode survives every reset but power-on
  always_ff @(posedge i_sys_clk or posedge i_por) begin
    if (i_por) begin
      vmode <= option_bank_pkg::VMODE_RESET;
    end else begin
      vmode <= next_vmode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Option fan-out

  logic slow_x;
  logic range_x;
  assign slow_x  = st.opt2[option_bank_pkg::SLOW_XTAL_BIT];
  assign range_x = st.opt3[option_bank_pkg::RANGE_BIT];

  always_comb begin
    o_options = '0;
    o_options.watchdog_disable =
      st.opt1[option_bank_pkg::WDOG_DIS_BIT];
    o_options.watchdog_timeout_cycles =
      st.opt1[option_bank_pkg::WDOG_PER_BIT] ?
      option_bank_pkg::WDOG_SHORT_CYCLES :
      option_bank_pkg::WDOG_LONG_CYCLES;
    o_options.detector_powered =
      !st.opt1[option_bank_pkg::DET_PWROFF_BIT];
    o_options.detector_active_in_stop =
      st.opt1[option_bank_pkg::DET_STOP_BIT];
    o_options.detector_voltage_mode = vmode;
    o_options.stop_enable = st.opt1[option_bank_pkg::STOP_EN_BIT];
    o_options.serial_baud_source =
      st.opt2[option_bank_pkg::BAUD_SRC_BIT];
    o_options.osc_input_pin_is_clock =
      st.opt2[option_bank_pkg::EXT_CLK_BIT];
    o_options.osc_output_pin_is_crystal =
      st.opt2[option_bank_pkg::EXT_CLK_BIT] &&
      st.opt2[option_bank_pkg::XTAL_EN_BIT];
    o_options.monitor_stab_cycles =
      st.opt2[option_bank_pkg::XTAL_EN_BIT] ?
      option_bank_pkg::STAB_XTAL_CYCLES :
      option_bank_pkg::STAB_EXT_CYCLES;
    o_options.monitor_crystal_range =
      st.opt2[option_bank_pkg::XTAL_EN_BIT];
    o_options.slow_crystal_select = slow_x;
    o_options.crystal_range_code = {slow_x, range_x};
    o_options.amp_fast_enable = !slow_x && !range_x;
    o_options.amp_mid_enable  = !slow_x && range_x;
    o_options.amp_slow_enable = slow_x && !range_x;
    o_options.timebase_prescale_select =
      st.opt2[option_bank_pkg::TB_PRE_BIT];
    o_options.slave_select_pullup_enable =
      !st.opt2[option_bank_pkg::SS_PU_DIS_BIT];
    o_options.serial_tx_slew_ctrl =
      st.opt3[option_bank_pkg::TX_SLEW_BIT];
    o_options.spi_slew_ctrl =
      st.opt3[option_bank_pkg::SPI_SLEW_BIT];
    o_options.clock_out_slew_ctrl =
      st.opt3[option_bank_pkg::CLK_SLEW_BIT];
    o_options.port_slew_ctrl =
      st.opt3[option_bank_pkg::PORT_SLEW_BIT];
    o_options.serial_pin_location =
      st.opt3[option_bank_pkg::SER_LOC_BIT];
    o_options.spi_pin_location =
      st.opt3[option_bank_pkg::SPI_LOC_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // Stop, detector and clock gating

  assign o_detector_on_in_stop =
    st.opt1[option_bank_pkg::DET_STOP_BIT] &&
    !st.opt1[option_bank_pkg::DET_PWROFF_BIT];

  assign o_detector_reset_to_sys =
    i_detector_reset_req &&
    !st.opt1[option_bank_pkg::DET_RSTINH_BIT];

  // Detector-caused exits ignore the short option
  assign o_stop_recovery_cycles =
    (st.opt1[option_bank_pkg::SHORT_REC_BIT] &&
     !i_stop_exit_by_detector) ?
    option_bank_pkg::REC_SHORT_CYCLES :
    option_bank_pkg::REC_LONG_CYCLES;

  assign o_stop_execute =
    i_stop_opcode && st.opt1[option_bank_pkg::STOP_EN_BIT];
  assign o_stop_illegal =
    i_stop_opcode && !st.opt1[option_bank_pkg::STOP_EN_BIT];

  assign o_gen_clocks_run =
    !i_in_stop_mode || st.opt2[option_bank_pkg::OSC_STOP_BIT];

endmodule

`default_nettype wire

// file: testbench/option_bank_props.sv
// Assertion checker for the write-once option register bank
`timescale 1ns/100ps
`default_nettype none

module option_bank_props (
  input wire logic                         i_sys_clk,
  input wire logic                         i_rst,
  input wire logic                         i_awvalid,
  input wire logic                         o_awready,
  input wire logic                         i_wvalid,
  input wire logic                         o_wready,
  input wire logic                         o_bvalid,
  input wire logic [1:0]                   o_bresp,
  input wire logic                         i_bready,
  input wire logic                         i_arvalid,
  input wire logic                         o_arready,
  input wire logic                         o_rvalid,
  input wire logic                         i_detector_reset_req,
  input wire logic                         i_stop_exit_by_detector,
  input wire logic                         i_stop_opcode,
  input wire logic                         i_in_stop_mode,
  input wire option_bank_pkg::option_out_t o_options,
  input wire logic                         o_detector_reset_to_sys,
  input wire logic                         o_detector_on_in_stop,
  input wire logic [12:0]                  o_stop_recovery_cycles,
  input wire logic                         o_stop_execute,
  input wire logic                         o_stop_illegal,
  input wire logic                         o_gen_clocks_run
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  opt_change_a: assert property (!$stable(o_options) |-> o_bvalid)
    else $error("options changed outside a write");
  wr_answer_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write response late");
  b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
    else $error("read response late");
  det_gate_a: assert property (o_detector_reset_to_sys |-> i_detector_reset_req)
    else $error("detector reset without request");
  det_stop_a: assert property (o_detector_on_in_stop |-> o_options.detector_powered)
    else $error("detector on in stop while powered off");
  long_rec_a: assert property (i_stop_exit_by_detector |-> o_stop_recovery_cycles == 13'd4096)
    else $error("detector exit not long recovery");
  stop_gate_a: assert property (o_stop_illegal == (i_stop_opcode && !o_options.stop_enable))
    else $error("stop opcode gating wrong");
  clk_run_a: assert property (!i_in_stop_mode |-> o_gen_clocks_run)
    else $error("clocks held outside stop");
  range_force_a: assert property (o_options.slow_crystal_select |-> !o_options.crystal_range_code[0])
    else $error("range bit set with slow crystal");
  cover property (o_bvalid && o_bresp == 2'h2);
  cover property (o_stop_illegal);
  cover property (o_detector_reset_to_sys);
endmodule

bind write_once_option_registers option_bank_props props (.*);

`default_nettype wire

// file: testbench/test_write_once_option_registers.sv
// Self-checking bench for the write-once option register bank
`timescale 1ns/100ps
`default_nettype none

module test_write_once_option_registers;
  logic        i_sys_clk, i_rst, i_por, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic        i_detector_reset_req, i_stop_exit_by_detector, i_stop_opcode, i_in_stop_mode;
  logic [7:0]  i_awaddr, i_araddr;
  logic [2:0]  i_awprot, i_arprot, wrt;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0]  i_wstrb;
  logic [1:0]  o_bresp, o_rresp;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic        o_detector_reset_to_sys, o_detector_on_in_stop, o_stop_execute, o_stop_illegal, o_gen_clocks_run;
  logic [12:0] o_stop_recovery_cycles;
  logic [7:0]  m [3];
  logic [7:0]  adr [3];
  int          fail_count, total_checks;
  option_bank_pkg::option_out_t o_options, eo;

  write_once_option_registers DUT (.*);

  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    #2000000;
    fail_count++;
    test_done();
  end
  ////////////////////////////////////////
  task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s, input logic [1:0] er);
    logic       ad, dd, ra, rw, bv;
    logic [1:0] br;
    ad = 1'b0;
    dd = 1'b0;
    i_awaddr <= a;
    i_wdata <= ($urandom() & 32'hFFFFFF00) | {24'h0, d};
    i_wstrb <= {3'($urandom()), s};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    // Readies are settled mid-cycle, as the next rising edge sees them
    while (!(ad && dd)) begin
      @(negedge i_sys_clk);
      ra = o_awready;
      rw = o_wready;
      @(posedge i_sys_clk);
      if (!ad && ra) begin
        ad = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (!dd && rw) begin
        dd = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    i_bready <= 1'b1;
    do begin
      @(negedge i_sys_clk);
      bv = o_bvalid;
      br = o_bresp;
      @(posedge i_sys_clk);
    end while (!bv);
    i_bready <= 1'b0;
    check("bresp", 64'(br), 64'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    logic        ok;
    logic [31:0] dat;
    logic [1:0]  rr;
    i_araddr <= a;
    i_arvalid <= 1'b1;
    do begin
      @(negedge i_sys_clk);
      ok = o_arready;
      @(posedge i_sys_clk);
    end while (!ok);
    i_arvalid <= 1'b0;
    i_rready <= 1'b1;
    do begin
      @(negedge i_sys_clk);
      ok = o_rvalid;
      dat = o_rdata;
      rr = o_rresp;
      @(posedge i_sys_clk);
    end while (!ok);
    i_rready <= 1'b0;
    check("rdata", 64'(dat), 64'(e));
    check("rresp", 64'(rr), 64'(er));
  endtask

  task automatic do_reset(input logic p);
    i_rst <= 1'b1;
    i_por <= p;
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    i_por <= 1'b0;
    m[0] = p ? 8'h00 : (m[0] & 8'h08);
    m[1] = 8'h00;
    m[2] = 8'h00;
    wrt = 3'h0;
  endtask

  task automatic put(input int i, input logic [7:0] d, input logic s);
    wr(adr[i], d, s, 2'h0);
    if (s && !wrt[i]) begin
      wrt[i] = 1'b1;
      m[i] = d & (i == 0 ? 8'hFF : 8'h7F);
      if (i == 2 && m[1][4]) m[2][6] = 1'b0;
    end
    if (i == 1 && s && m[1][4]) m[2][6] = 1'b0;
  endtask

  task automatic side_check();
    i_detector_reset_req <= 1'($urandom());
    i_stop_exit_by_detector <= 1'($urandom());
    i_stop_opcode <= 1'($urandom());
    i_in_stop_mode <= 1'($urandom());
    @(posedge i_sys_clk);
    check("side", 64'({o_detector_reset_to_sys, o_detector_on_in_stop, o_stop_recovery_cycles,
      o_stop_execute, o_stop_illegal, o_gen_clocks_run}), 64'({i_detector_reset_req & ~m[0][5],
      m[0][6] & ~m[0][4], (m[0][2] & ~i_stop_exit_by_detector) ? 13'd32 : 13'd4096,
      i_stop_opcode & m[0][1], i_stop_opcode & ~m[0][1], ~i_in_stop_mode | m[1][1]}));
  endtask

  always_comb begin
    eo = '0;
    eo.watchdog_disable = m[0][0];
    eo.watchdog_timeout_cycles = m[0][7] ? 18'd8176 : 18'd262128;
    eo.detector_powered = ~m[0][4];
    eo.detector_active_in_stop = m[0][6];
    eo.detector_voltage_mode = m[0][3];
    eo.stop_enable = m[0][1];
    eo.serial_baud_source = m[1][6];
    eo.osc_input_pin_is_clock = m[1][3];
    eo.osc_output_pin_is_crystal = m[1][3] & m[1][5];
    eo.monitor_stab_cycles = m[1][5] ? 13'd4096 : 13'd16;
    eo.monitor_crystal_range = m[1][5];
    eo.slow_crystal_select = m[1][4];
    eo.crystal_range_code = {m[1][4], m[2][6]};
    eo.amp_fast_enable = ({m[1][4], m[2][6]} == 2'b00);
    eo.amp_mid_enable = ({m[1][4], m[2][6]} == 2'b01);
    eo.amp_slow_enable = ({m[1][4], m[2][6]} == 2'b10);
    eo.timebase_prescale_select = m[1][2];
    eo.slave_select_pullup_enable = ~m[1][0];
    {eo.serial_tx_slew_ctrl, eo.spi_slew_ctrl, eo.clock_out_slew_ctrl, eo.port_slew_ctrl} = m[2][5:2];
    {eo.serial_pin_location, eo.spi_pin_location} = m[2][1:0];
  end
  ////////////////////////////////////////
  initial begin
    {i_rst, i_por, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    {i_detector_reset_req, i_stop_exit_by_detector, i_stop_opcode, i_in_stop_mode} = '0;
    {i_awaddr, i_araddr, i_awprot, i_arprot, i_wdata, i_wstrb} = '0;
    adr = '{option_bank_pkg::OPT1_ADDR, option_bank_pkg::OPT2_ADDR, option_bank_pkg::OPT3_ADDR};
    m = '{8'h00, 8'h00, 8'h00};
    fail_count = 0;
    total_checks = 0;
    void'($urandom(83));
    do_reset(1'b1);
    for (int i = 0; i < 3; i++) rd(adr[i], 8'h00, 2'h0);
    wr(8'h00, 8'hFF, 1'b1, 2'h2);
    rd(8'h04, 8'h00, 2'h2);
    wr(option_bank_pkg::STATUS_ADDR, 8'hFF, 1'b1, 2'h0);
    rd(option_bank_pkg::STATUS_ADDR, 8'h00, 2'h0);
    for (int k = 0; k < 24; k++) begin
      for (int j = 0; j < 6; j++) put((j + k) % 3, 8'($urandom()), ($urandom() % 4) != 0);
      for (int i = 0; i < 3; i++) rd(adr[i], m[i], 2'h0);
      rd(option_bank_pkg::STATUS_ADDR, {5'h0, wrt}, 2'h0);
      check("options", 64'(o_options), 64'(eo));
      repeat (4) side_check();
      do_reset(1'($urandom()));
      rd(adr[0], m[0], 2'h0);
    end
    test_done();
  end
endmodule

`default_nettype wire
